// *** gcab_ctrl.sv ***
// Arm, load bank, delay step, hardware disarm and snapshot control of two general counters.
//
// Overview of operation
// - Add delay step to reload A after reload.
// - Delay step adder wraps without any flag.
// - Sampling mode: gate edge starts delayed pulse.
// - Command bit 0 arms its own counter.
// - Counter stays armed until hardware or software disarm.
// - Command bit 13 arms the other counter.
// - Status bits 8 and 9 show armed state.
// - Joint status bits 0 and 1 show bank.
// - Bit 12 selects bank unarmed, enables swap armed.
// - Bit 11 picks swap trigger: gate or software.
// - Bit 10 requests a bank swap, self clearing.
// - Policy field selects terminal count or gate disarm.
// - Bit 3 pulses the hysteresis clear output.
// - Snapshot readable while counting, count undisturbed.
// - Gate capture sets the gate event flag.
// - Pin driven only while drive enable set.
// - Command bit 4 disarms its counter.
// - Status bits 2 and 3 show counting.
`include "gcab_defines.svh"
`default_nettype none
module gcab_ctrl
  import gcab_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Counter inputs.
  input  wire logic [1:0]  src_i,
  input  wire logic [1:0]  gate_i,
  // Counter outputs.
  output logic      [1:0]  pin_o,
  output logic      [1:0]  pin_oe_o,
  output logic      [1:0]  hyst_clear_o,
  output logic      [1:0]  gate_event_o
);

  // **********************************************
  // State and bus decode
  // **********************************************
  gcab_state_t       st_q;
  gcab_state_t       st_d;

  logic [7:0]        idx;
  logic              wr_now;
  logic [31:0]       wd;
  logic [1:0]        wr_cmd;
  logic [1:0]        wr_mode;
  logic [1:0]        wr_step;
  logic [1:0]        wr_la;
  logic [1:0]        wr_lb;
  logic              wr_ctrl;
  logic              wr_evt;
  logic [1:0]        arm_req;
  logic [1:0]        dis_req;
  logic [1:0]        gate_act;
  logic [1:0]        edge_on;
  logic [1:0]        edge_off;
  logic [1:0]        counting;
  logic [1:0]        hw_dis;
  logic [1:0]        rl_ev;
  logic [1:0][23:0]  a_sum;
  logic [1:0][23:0]  a_cur;
  logic [1:0]        armed_v;
  logic [1:0]        bank_v;

  // Merges a byte-laned write into a 24-bit value.
  function automatic logic [23:0] merge24(input logic [23:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
    logic [23:0] r;
    r = old_v;
    for (int b = 0; b < 3; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign idx     = adr_i[9:2];
  // A write takes effect at the edge where the master samples ack.
  assign wr_now  = cyc_i & stb_i & we_i & st_q.ack;
  assign wd      = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wr_ctrl = wr_now & (idx == `GCAB_IDX_CTRL);
  assign wr_evt  = wr_now & (idx == `GCAB_IDX_EVT);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      wr_cmd[i]   = wr_now & (idx == (i == 0 ? `GCAB_IDX_CMD0 : `GCAB_IDX_CMD1));
      wr_mode[i]  = wr_now & (idx == (i == 0 ? `GCAB_IDX_MODE0 : `GCAB_IDX_MODE1));
      wr_step[i]  = wr_now & (idx == (i == 0 ? `GCAB_IDX_STEP0 : `GCAB_IDX_STEP1));
      wr_la[i]    = wr_now & (idx == (i == 0 ? `GCAB_IDX_LOADA0 : `GCAB_IDX_LOADA1));
      wr_lb[i]    = wr_now & (idx == (i == 0 ? `GCAB_IDX_LOADB0 : `GCAB_IDX_LOADB1));
      gate_act[i] = gate_i[i] ^ st_q.cnt[i].gpol;
      edge_on[i]  = gate_act[i] & ~st_q.gate_prev[i];
      edge_off[i] = ~gate_act[i] & st_q.gate_prev[i];
      armed_v[i]  = st_q.cnt[i].armed;
      bank_v[i]   = st_q.cnt[i].bank;
      a_cur[i]    = st_q.cnt[i].load_a[st_q.cnt[i].bank];
    end
    arm_req[0] = (wr_cmd[0] & wd[`GCAB_CMD_ARM]) | (wr_cmd[1] & wd[`GCAB_CMD_XARM]);
    arm_req[1] = (wr_cmd[1] & wd[`GCAB_CMD_ARM]) | (wr_cmd[0] & wd[`GCAB_CMD_XARM]);
    dis_req[0] = (wr_cmd[0] & wd[`GCAB_CMD_DISARM]) | (wr_cmd[1] & wd[`GCAB_CMD_XDISARM]);
    dis_req[1] = (wr_cmd[1] & wd[`GCAB_CMD_DISARM]) | (wr_cmd[0] & wd[`GCAB_CMD_XDISARM]);
    for (int i = 0; i < 2; i++) begin
      counting[i] = st_q.cnt[i].armed & (st_q.cnt[i].phase != GCAB_PH_IDLE) &
                    (st_q.cnt[i].equivalent_time_sampling | gate_act[i]);
    end
  end

  // **********************************************
  // Next state
  // **********************************************
  always_comb begin
    gcab_cnt_t c;
    logic      tick;
    logic      rl;
    logic      stop_tc;
    logic      stop_gate;
    logic      tb;
    c         = '0;
    tick      = 1'b0;
    rl        = 1'b0;
    stop_tc   = 1'b0;
    stop_gate = 1'b0;
    tb        = 1'b0;
    st_d      = st_q;
    hw_dis    = 2'b00;
    rl_ev     = 2'b00;
    a_sum     = '0;
    st_d.gate_prev = gate_act;
    st_d.ack  = cyc_i & stb_i & ~st_q.ack;
    for (int i = 0; i < 2; i++) begin
      c         = st_q.cnt[i];
      rl        = 1'b0;
      stop_tc   = 1'b0;
      stop_gate = 1'b0;
      c.hyst    = 1'b0;
      if (wr_cmd[i]) begin
        c.swap_src = wd[`GCAB_CMD_SWAP_SRC];
        c.swap_en  = wd[`GCAB_CMD_SWAP_EN];
        c.hyst     = wd[`GCAB_CMD_HYST];
      end
      if (wr_mode[i]) begin
        c.equivalent_time_sampling    = wd[`GCAB_MODE_ETS];
        c.policy = wd[`GCAB_MODE_POL_HI:`GCAB_MODE_POL_LO];
        c.gpol   = wd[`GCAB_MODE_GPOL];
      end
      if (wr_step[i]) begin
        c.step = wd[7:0];
      end
      if (wr_ctrl) begin
        c.snap_trk = wd[`GCAB_CTRL_TRACK0 + i];
        c.pin_en   = wd[`GCAB_CTRL_PINEN0 + i];
        c.pin_src  = wd[`GCAB_CTRL_PINSRC0 + i];
      end
      // While armed, software loads the bank that is not in use.
      tb = c.armed ? ~c.bank : c.bank;
      if (wr_la[i]) begin
        c.load_a[tb] = merge24(c.load_a[tb], dat_i, sel_i);
      end
      if (wr_lb[i]) begin
        c.load_b[tb] = merge24(c.load_b[tb], dat_i, sel_i);
      end
      if (wr_evt && wd[i]) begin
        c.evt = 1'b0;
      end
      tick = src_i[i] & (c.equivalent_time_sampling | gate_act[i]);
      if (st_q.cnt[i].armed) begin
        unique case (c.phase)
          GCAB_PH_IDLE: begin
            if (!c.equivalent_time_sampling || edge_on[i]) begin
              rl = 1'b1;
            end
          end
          GCAB_PH_DELAY: begin
            if (tick) begin
              if (c.count == 24'h00_0000) begin
                c.count = c.load_b[c.bank];
                c.phase = GCAB_PH_WIDTH;
                c.pin   = 1'b1;
              end else begin
                c.count = c.count - 24'h00_0001;
              end
            end
          end
          GCAB_PH_WIDTH: begin
            if (tick) begin
              if (c.count == 24'h00_0000) begin
                c.pin = 1'b0;
                if (c.equivalent_time_sampling) begin
                  c.phase = GCAB_PH_IDLE;
                  stop_tc = 1'b1;
                end else begin
                  rl = 1'b1;
                end
              end else begin
                c.count = c.count - 24'h00_0001;
              end
            end
          end
          default: begin
            c.phase = GCAB_PH_IDLE;
          end
        endcase
        stop_gate = ~c.equivalent_time_sampling & edge_off[i] & (st_q.cnt[i].phase != GCAB_PH_IDLE);
        if (rl) begin
          if (c.swap_pend) begin
            c.bank      = ~c.bank;
            c.swap_pend = 1'b0;
          end
          c.count = c.load_a[c.bank];
          a_sum[i] = c.load_a[c.bank] + {16'h0000, c.step};
          c.load_a[c.bank] = a_sum[i];
          c.phase = GCAB_PH_DELAY;
        end
        if (edge_on[i]) begin
          c.capt = st_q.cnt[i].count;
          c.evt  = 1'b1;
        end
        hw_dis[i] = (c.policy[0] & stop_tc) | (c.policy[1] & stop_gate);
      end
      rl_ev[i] = rl;
      if (c.swap_wait && edge_on[i]) begin
        c.swap_pend = 1'b1;
        c.swap_wait = 1'b0;
      end
      if (wr_cmd[i] && wd[`GCAB_CMD_SWAP_REQ] && st_q.cnt[i].armed && c.swap_en) begin
        if (c.swap_src) begin
          c.swap_pend = 1'b1;
        end else begin
          c.swap_wait = 1'b1;
        end
      end
      if (arm_req[i] && !st_q.cnt[i].armed) begin
        c.armed = 1'b1;
        c.phase = GCAB_PH_IDLE;
      end
      if (dis_req[i] || hw_dis[i]) begin
        c.armed     = 1'b0;
        c.phase     = GCAB_PH_IDLE;
        c.pin       = 1'b0;
        c.swap_pend = 1'b0;
        c.swap_wait = 1'b0;
      end
      if (!c.armed) begin
        c.bank = c.swap_en;
      end
      if (c.snap_trk) begin
        c.snap = st_q.cnt[i].count;
      end
      st_d.cnt[i] = c;
    end
    // Read data is latched in the cycle before ack.
    st_d.rdata = `GCAB_RST_WORD;
    if (cyc_i && stb_i && !st_q.ack && !we_i) begin
      case (idx)
        `GCAB_IDX_STATUS: begin
          st_d.rdata[`GCAB_ST_COUNT0 +: 2] = counting;
          st_d.rdata[`GCAB_ST_ARMED0 +: 2] = armed_v;
        end
        `GCAB_IDX_CMD0, `GCAB_IDX_CMD1: begin
          st_d.rdata[`GCAB_CMD_SWAP_SRC] = st_q.cnt[idx[0] ? 1 : 0].swap_src;
          st_d.rdata[`GCAB_CMD_SWAP_EN]  = st_q.cnt[idx[0] ? 1 : 0].swap_en;
        end
        `GCAB_IDX_JOINT: st_d.rdata[1:0]  = bank_v;
        `GCAB_IDX_SNAP0: st_d.rdata[23:0] = st_q.cnt[0].snap;
        `GCAB_IDX_SNAP1: st_d.rdata[23:0] = st_q.cnt[1].snap;
        `GCAB_IDX_CAPT0: st_d.rdata[23:0] = st_q.cnt[0].capt;
        `GCAB_IDX_CAPT1: st_d.rdata[23:0] = st_q.cnt[1].capt;
        `GCAB_IDX_CTRL: begin
          st_d.rdata[5:0] = {st_q.cnt[1].pin_src, st_q.cnt[0].pin_src, st_q.cnt[1].pin_en,
                             st_q.cnt[0].pin_en, st_q.cnt[1].snap_trk, st_q.cnt[0].snap_trk};
        end
        `GCAB_IDX_EVT: st_d.rdata[1:0] = {st_q.cnt[1].evt, st_q.cnt[0].evt};
        default: st_d.rdata = `GCAB_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // **********************************************
  // Outputs
  // **********************************************
  assign ack_o = st_q.ack;
  assign dat_o = st_q.rdata;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_o[i]        = st_q.cnt[i].pin & ~st_q.cnt[i].pin_src;
      pin_oe_o[i]     = st_q.cnt[i].pin_en;
      hyst_clear_o[i] = st_q.cnt[i].hyst;
      gate_event_o[i] = st_q.cnt[i].evt;
    end
  end

  // **********************************************
  // Assertions
  // **********************************************
  AST_ARM: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cmd[0] && wd[`GCAB_CMD_ARM] && !dis_req[0] |=> st_q.cnt[0].armed)
    else $error("counter 0 not armed after arm strobe");
  AST_CROSS: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cmd[0] && wd[`GCAB_CMD_XARM] && !dis_req[1] |=> st_q.cnt[1].armed)
    else $error("counter 1 not armed by cross arm");
  AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.cnt[0].armed && !dis_req[0] && !hw_dis[0] |=> st_q.cnt[0].armed)
    else $error("counter 0 lost armed state without disarm");
  AST_DISARM: assert property (@(posedge clk_i) disable iff (rst_i)
    dis_req[1] |=> !st_q.cnt[1].armed && st_q.cnt[1].phase == GCAB_PH_IDLE)
    else $error("counter 1 still armed after disarm strobe");
  AST_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && !we_i && idx == `GCAB_IDX_STATUS |-> dat_o[9:8] == $past(armed_v))
    else $error("status armed bits wrong");
  AST_JOINT: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && !we_i && idx == `GCAB_IDX_JOINT |-> dat_o[1:0] == $past(bank_v))
    else $error("joint status bank bits wrong");
  AST_UNARMED_BANK: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_q.cnt[0].armed |-> st_q.cnt[0].bank == st_q.cnt[0].swap_en)
    else $error("unarmed bank differs from bank select");
  AST_SWREQ: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cmd[0] && wd[`GCAB_CMD_SWAP_REQ] && wd[`GCAB_CMD_SWAP_SRC] && wd[`GCAB_CMD_SWAP_EN]
    && st_q.cnt[0].armed && !dis_req[0] && !hw_dis[0] |=> st_q.cnt[0].swap_pend)
    else $error("software swap request not pending");
  AST_SWAP_AT_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.cnt[0].armed && $past(st_q.cnt[0].armed) && $changed(st_q.cnt[0].bank) |-> $past(rl_ev[0]))
    else $error("bank swapped outside a reload");
  AST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    rl_ev[0] && !wr_la[0] && !hw_dis[0] && !dis_req[0] |=> a_cur[0] == $past(a_sum[0]))
    else $error("reload value A not stepped after reload");
  AST_POLICY: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.cnt[0].policy == 2'b00 |-> !hw_dis[0])
    else $error("hardware disarm with policy zero");
  AST_HYST: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_cmd[1] && wd[`GCAB_CMD_HYST] |=> hyst_clear_o[1] ##1 !hyst_clear_o[1])
    else $error("hysteresis clear not a single pulse");
  AST_EVT: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.cnt[0].armed && edge_on[0] |=> st_q.cnt[0].evt && st_q.cnt[0].capt == $past(st_q.cnt[0].count))
    else $error("gate capture did not set event flag");
  AST_ETS_START: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q.cnt[0].armed && st_q.cnt[0].equivalent_time_sampling && st_q.cnt[0].phase == GCAB_PH_IDLE && !edge_on[0]
    && !dis_req[0] |=> st_q.cnt[0].phase == GCAB_PH_IDLE)
    else $error("sampling pulse started without gate edge");
  AST_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && !wd[`GCAB_CTRL_PINEN0] |=> !pin_oe_o[0])
    else $error("pin driven after drive enable cleared");

endmodule
`default_nettype wire

// *** gcab_defines.svh ***
// Register indices, field positions and reset values of the counter arm and bank control block.
`ifndef GCAB_DEFINES_SVH
`define GCAB_DEFINES_SVH

// **********************************************
// Register indices (byte address is index times four)
// **********************************************
`define GCAB_IDX_STATUS   8'h04
`define GCAB_IDX_CMD0     8'h06
`define GCAB_IDX_CMD1     8'h07
`define GCAB_IDX_MODE0    8'h1A
`define GCAB_IDX_MODE1    8'h1B
`define GCAB_IDX_JOINT    8'h1B
`define GCAB_IDX_STEP0    8'h44
`define GCAB_IDX_STEP1    8'h45
`define GCAB_IDX_LOADA0   8'h48
`define GCAB_IDX_LOADB0   8'h49
`define GCAB_IDX_LOADA1   8'h4A
`define GCAB_IDX_LOADB1   8'h4B
`define GCAB_IDX_SNAP0    8'h4C
`define GCAB_IDX_SNAP1    8'h4D
`define GCAB_IDX_CAPT0    8'h4E
`define GCAB_IDX_CAPT1    8'h4F
`define GCAB_IDX_CTRL     8'h50
`define GCAB_IDX_EVT      8'h51

// **********************************************
// Field positions
// **********************************************
`define GCAB_CMD_ARM       0
`define GCAB_CMD_HYST      3
`define GCAB_CMD_DISARM    4
`define GCAB_CMD_SWAP_REQ  10
`define GCAB_CMD_SWAP_SRC  11
`define GCAB_CMD_SWAP_EN   12
`define GCAB_CMD_XARM      13
`define GCAB_CMD_XDISARM   15
`define GCAB_MODE_ETS      0
`define GCAB_MODE_POL_LO   10
`define GCAB_MODE_POL_HI   11
`define GCAB_MODE_GPOL     13
`define GCAB_ST_COUNT0     2
`define GCAB_ST_ARMED0     8
`define GCAB_CTRL_TRACK0   0
`define GCAB_CTRL_PINEN0   2
`define GCAB_CTRL_PINSRC0  4

// **********************************************
// Reset values
// **********************************************
`define GCAB_RST_WORD      32'h0000_0000

`endif

// *** gcab_pkg.sv ***
// Types shared by the counter arm and bank control block.
`default_nettype none
package gcab_pkg;

  typedef enum logic [1:0] {GCAB_PH_IDLE, GCAB_PH_DELAY, GCAB_PH_WIDTH} gcab_phase_t;

  typedef struct packed {
    logic              armed;
    gcab_phase_t       phase;
    logic [23:0]       count;
    logic [1:0][23:0]  load_a;
    logic [1:0][23:0]  load_b;
    logic              bank;
    logic              swap_en;
    logic              swap_src;
    logic              swap_pend;
    logic              swap_wait;
    logic              equivalent_time_sampling;
    logic              gpol;
    logic [1:0]        policy;
    logic [7:0]        step;
    logic [23:0]       snap;
    logic              snap_trk;
    logic [23:0]       capt;
    logic              evt;
    logic              pin_en;
    logic              pin_src;
    logic              pin;
    logic              hyst;
  } gcab_cnt_t;

  typedef struct packed {
    gcab_cnt_t [1:0]   cnt;
    logic              ack;
    logic [31:0]       rdata;
    logic [1:0]        gate_prev;
  } gcab_state_t;

endpackage
`default_nettype wire

// *** gcab_far.sv ***
// Model of the gate and source signals that drive the two counters.
`default_nettype none
module gcab_far (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Requests from the bench.
  input  wire logic [1:0] run_i,
  input  wire logic       slow_i,
  input  wire logic [1:0] gate_lvl_i,
  // Counter inputs.
  output logic      [1:0] src_o,
  output logic      [1:0] gate_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q   <= 1'b0;
      src_o  <= 2'b00;
      gate_o <= 2'b00;
    end else begin
      ph_q   <= ~ph_q;
      // A slow source ticks only every other cycle.
      src_o  <= run_i & {2{~slow_i | ph_q}};
      gate_o <= gate_lvl_i;
    end
  end
endmodule
`default_nettype wire

// *** gcab_tb.sv ***
// Self-checking bench of the counter arm and bank control block.
`include "gcab_defines.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ARM = 32'h0000_0001, HYS = 32'h0000_0008, DIS = 32'h0000_0010;
  localparam logic [31:0] SREQ = 32'h0000_0400, SSRC = 32'h0000_0800, SEN = 32'h0000_1000;
  localparam logic [31:0] XARM = 32'h0000_2000, XDIS = 32'h0000_8000;
  localparam logic [7:0]  ST = `GCAB_IDX_STATUS;
  logic        clk_i, rst_i, cyc, stb, we, ack_o, slow;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, q, s1;
  logic [1:0]  src, gate, pin_o, pin_oe_o, hyst_o, evt_o, run, glv;
  int          fails, n_checks, cyc_n, hyst_n, hi_n, lo_n, step;
  int          lows[$];

  gcab_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .src_i(src), .gate_i(gate),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .hyst_clear_o(hyst_o), .gate_event_o(evt_o));
  gcab_far far_u (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .slow_i(slow), .gate_lvl_i(glv),
    .src_o(src), .gate_o(gate));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  // One classic cycle; released only at the edge where ack is seen.
  task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] i, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, i, '0);
    chk(nm, e, q & m);
  endtask

  // Counts strobe cycles, pulse cycles and low runs of the counter 0 pin.
  always @(posedge clk_i) begin
    cyc_n++;
    if (hyst_o[0] === 1'b1) hyst_n++;
    if (pin_o[0] === 1'b1) hi_n++;
    if (pin_o[0] === 1'b0) begin
      lo_n++;
    end else if (lo_n > 0) begin
      lows.push_back(lo_n);
      lo_n = 0;
    end
    if (cyc_n == 20000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    {cyc, stb, we, slow, run, glv, adr, dat} = '0;
    sel = 4'hf;
    {fails, n_checks, cyc_n, hyst_n, hi_n, lo_n} = '0;
    void'($urandom(7826));
    step = 1 + ($urandom % 6);
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("status", ST, 32'hffff_ffff, 0);
    rd("joint bank", `GCAB_IDX_JOINT, 32'h0000_0003, 0);
    rd("unmapped", 8'h30, 32'hffff_ffff, 0);
    $display("test reset done");
    wb(1, `GCAB_IDX_CMD0, ARM);
    rd("armed", ST, 32'h0000_0300, 32'h0000_0100);
    wb(1, `GCAB_IDX_CMD0, XARM);
    repeat (20) @(posedge clk_i);
    rd("armed", ST, 32'h0000_0300, 32'h0000_0300);
    rd("cmd strobes", `GCAB_IDX_CMD0, 32'hffff_ffff, 0);
    wb(1, `GCAB_IDX_CMD1, DIS);
    rd("armed", ST, 32'h0000_0300, 32'h0000_0100);
    wb(1, `GCAB_IDX_CMD1, XDIS);
    rd("armed", ST, 32'h0000_0300, 0);
    wb(1, `GCAB_IDX_CMD0, SEN);
    rd("joint bank", `GCAB_IDX_JOINT, 32'h0000_0001, 1);
    wb(1, `GCAB_IDX_CMD0, 0);
    rd("joint bank", `GCAB_IDX_JOINT, 32'h0000_0001, 0);
    hyst_n = 0;
    wb(1, `GCAB_IDX_CMD0, ARM | HYS);
    repeat (4) @(posedge clk_i);
    chk("hyst pulses", 1, hyst_n);
    wb(1, `GCAB_IDX_CMD0, DIS);
    wb(1, `GCAB_IDX_CMD1, ARM | HYS);
    @(posedge clk_i);
    chk("hyst1 pulse", 1, 32'(hyst_o[1]));
    @(posedge clk_i);
    chk("hyst1 end", 0, 32'(hyst_o[1]));
    wb(1, `GCAB_IDX_CMD1, DIS);
    $display("test arm done");
    wb(1, `GCAB_IDX_LOADA0, 4);
    wb(1, `GCAB_IDX_LOADB0, 1);
    wb(1, `GCAB_IDX_STEP0, step);
    wb(1, `GCAB_IDX_CTRL, 32'h0000_000D);
    @(posedge clk_i);
    chk("pin enable", 3, 32'(pin_oe_o));
    glv[0] <= 1'b1;
    run[0] <= 1'b1;
    lows.delete();
    wb(1, `GCAB_IDX_CMD0, ARM);
    rd("counting", ST, 32'h0000_0004, 32'h0000_0004);
    wb(0, `GCAB_IDX_SNAP0, 0);
    s1 = q;
    wb(0, `GCAB_IDX_SNAP0, 0);
    if (q !== s1) wb(0, `GCAB_IDX_SNAP0, 0);
    chk("snapshot range", 1, 32'(q < 32'h0000_0100));
    wb(1, `GCAB_IDX_CTRL, 32'h0000_0004);
    wb(0, `GCAB_IDX_SNAP0, 0);
    s1 = q;
    rd("frozen snapshot", `GCAB_IDX_SNAP0, 32'hffff_ffff, s1);
    for (int k = 0; k < 600 && lows.size() < 5; k++) @(posedge clk_i);
    for (int k = 1; k < 4; k++) chk("delay growth", step, lows[k + 1] - lows[k]);
    wb(1, `GCAB_IDX_CTRL, 32'h0000_0014);
    hi_n = 0;
    repeat (150) @(posedge clk_i);
    chk("pin source low", 0, hi_n);
    wb(1, `GCAB_IDX_CTRL, 32'h0000_0004);
    glv[0] <= 1'b0;
    repeat (3) @(posedge clk_i);
    glv[0] <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("gate event", 1, 32'(evt_o[0]));
    rd("event flag", `GCAB_IDX_EVT, 32'h0000_0001, 1);
    wb(1, `GCAB_IDX_EVT, 1);
    rd("event flag", `GCAB_IDX_EVT, 32'h0000_0001, 0);
    $display("test pulse train done");
    wb(1, `GCAB_IDX_STEP0, 0);
    for (int s = 0; s < 2; s++) begin
      wb(1, `GCAB_IDX_CMD0, DIS);
      wb(1, `GCAB_IDX_CMD0, SEN);
      wb(1, `GCAB_IDX_LOADA0, 6);
      wb(1, `GCAB_IDX_CMD0, 0);
      wb(1, `GCAB_IDX_LOADA0, 40);
      wb(1, `GCAB_IDX_CMD0, ARM);
      wb(1, `GCAB_IDX_CMD0, SEN | SREQ | (s ? SSRC : 0));
      rd("cmd readback", `GCAB_IDX_CMD0, 32'hffff_ffff, SEN | (s ? SSRC : 0));
      rd("bank before reload", `GCAB_IDX_JOINT, 32'h0000_0001, 0);
      if (s == 0) begin
        repeat (100) @(posedge clk_i);
        rd("bank without gate", `GCAB_IDX_JOINT, 32'h0000_0001, 0);
        glv[0] <= 1'b0;
        repeat (2) @(posedge clk_i);
        glv[0] <= 1'b1;
      end
      repeat (100) @(posedge clk_i);
      rd("bank swapped", `GCAB_IDX_JOINT, 32'h0000_0001, 1);
    end
    $display("test bank swap done");
    for (int p = 0; p < 4; p++) begin
      wb(1, `GCAB_IDX_CMD0, DIS);
      wb(1, `GCAB_IDX_MODE0, p << 10);
      wb(1, `GCAB_IDX_CMD0, ARM);
      repeat (8) @(posedge clk_i);
      glv[0] <= 1'b0;
      repeat (6) @(posedge clk_i);
      rd("gate disarm", ST, 32'h0000_0100, (p >= 2) ? 0 : 32'h0000_0100);
      glv[0] <= 1'b1;
    end
    $display("test disarm policy done");
    wb(1, `GCAB_IDX_CMD0, DIS);
    glv[0] <= 1'b0;
    slow   <= 1'b1;
    wb(1, `GCAB_IDX_STEP0, step);
    wb(1, `GCAB_IDX_MODE0, 32'h0000_0401);
    wb(1, `GCAB_IDX_LOADA0, 2);
    wb(1, `GCAB_IDX_CMD0, ARM);
    hi_n = 0;
    repeat (30) @(posedge clk_i);
    chk("pulse before trigger", 0, hi_n);
    glv[0] <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk("pulse after trigger", 1, 32'(hi_n > 0));
    rd("terminal disarm", ST, 32'h0000_0100, 0);
    wb(1, `GCAB_IDX_CTRL, 0);
    @(posedge clk_i);
    chk("pin disable", 0, 32'(pin_oe_o));
    $display("test sampling mode done");
    end_sim();
  end
endmodule
`default_nettype wire
